// file: hdl/dtc_consts.vh
// Constants for the drum transfer control block
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// ************************************************************
// Accumulator bit positions (bit 00 is the most significant)
// ************************************************************
`define DTC_AC_W 12
`define DTC_AC_B00 11
`define DTC_AC_B01 10
`define DTC_AC_B02 9
`define DTC_AC_B03 8
`define DTC_FIELD_HI 5
`define DTC_FIELD_LO 3
`define DTC_TRACK_HI 8
`define DTC_SECTOR_HI 7

// ************************************************************
// Widths, limits and reset values
// ************************************************************
`define DTC_FIELD_W 3
`define DTC_TRACK_W 9
`define DTC_SECTOR_W 8
`define DTC_WORD_W 6
`define DTC_SECTOR_MAX 8'h3F
`define DTC_WORDS_PER_SECTOR 6'h28
`define DTC_AC_ZERO 12'h000

// ************************************************************
// Timing
// ************************************************************
`define DTC_CLK_PERIOD_NS 100
`define DTC_HEAD_DELAY_US 40
// Head delay in clocks, sized to the one-shot counter: 40 us at a 100 ns clock
`define DTC_HEAD_DELAY_CYC 12'h190
`define DTC_DELAY_W 12

`endif

// file: hdl/dtc_oneshot.v
// Retriggerable one-shot delay counter
`timescale 1ns/10ps
`default_nettype none
module dtc_oneshot #(
  parameter WIDTH = 12,
  parameter [WIDTH-1:0] CYCLES = 12'h190
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_sync_b,
  // Trigger and output
  input wire trigger,
  output wire active
);
  reg [WIDTH-1:0] count;

  // Load on trigger, count down to zero
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count <= {WIDTH{1'b0}};
    end else if (trigger) begin
      count <= CYCLES;
    end else if (count != {WIDTH{1'b0}}) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign active = (count != {WIDTH{1'b0}});
endmodule // dtc_oneshot
`default_nettype wire

// file: hdl/dtc_top.v
// Drum transfer control: addressing, sector search, start/stop and status
`timescale 1ns/10ps
`default_nettype none
`include "dtc_consts.vh"
module dtc_top (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Processor I/O commands (one-cycle pulses on core_clk)
  input wire ext_addr_load_cmd,
  input wire sector_load_cmd,
  input wire track_load_and_start_cmd,
  input wire status_read_cmd,
  input wire clear_flag_cmd,
  input wire [`DTC_AC_W-1:0] buffered_accumulator,
  // Answers to the processor
  output reg [`DTC_AC_W-1:0] ac_in,
  output reg ac_clear,
  output reg [`DTC_FIELD_W-1:0] mem_field,
  output reg done_flag,
  output wire interrupt_request,
  // Drum timing and condition (asynchronous)
  input wire sector_pulse,
  input wire index_pulse,
  input wire drum_ready,
  output reg [`DTC_TRACK_W-1:0] track_addr,
  // Data, derandomizer and word-count boards (asynchronous)
  input wire last_word_last_bit_pulse,
  input wire buffer_break_req,
  input wire buffer_empty,
  input wire word_count_overflow,
  input wire data_error_in,
  output reg read_match,
  output reg write_match,
  output wire write_enable,
  output wire derand_activate,
  output reg data_board_activate,
  output reg forty_words,
  output reg drum_break_request,
  // Status levels
  output wire busy,
  output reg sector_missing,
  output reg illegal,
  output reg data_error
);

  // ************************************************************
  // Reset release
  // ************************************************************
  reg rst_meta;
  reg rst_sync_b;

  // Asynchronous assert, two-flop release
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // ************************************************************
  // Input synchronisers and edge detection
  // ************************************************************
  localparam NSYNC = 7;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;
  reg [NSYNC-1:0] sync_d;
  wire [NSYNC-1:0] rise;

  assign async_in = {data_error_in, word_count_overflow, buffer_empty, buffer_break_req,
                     last_word_last_bit_pulse, index_pulse, sector_pulse};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // Two flops, then a delayed copy for edges
      always @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_d[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_d[gi] <= sync_b[gi];
        end
      end
      assign rise[gi] = sync_b[gi] & ~sync_d[gi];
    end
  endgenerate

  wire sector_lvl = sync_b[0];
  wire sector_edge = rise[0];
  wire index_edge = rise[1];
  wire last_word_last_bit_pulse_edge = rise[2];
  wire break_lvl = sync_b[3];
  wire empty_lvl = sync_b[4];
  wire wc_ovf_lvl = sync_b[5];
  wire data_err_edge = rise[6];

  // Ready is a plain level; loss of it is sampled twice too
  reg ready_a;
  reg ready_s;

  // Ready synchroniser
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ready_a <= 1'b0;
      ready_s <= 1'b0;
    end else begin
      ready_a <= drum_ready;
      ready_s <= ready_a;
    end
  end

  // ************************************************************
  // Head-switch delay
  // ************************************************************
  wire head_delay;

  // Every track load restarts the delay
  dtc_oneshot #(
    .WIDTH(`DTC_DELAY_W),
    .CYCLES(`DTC_HEAD_DELAY_CYC)
  ) u_head_delay (
    .core_clk(core_clk),
    .rst_sync_b(rst_sync_b),
    .trigger(track_load_and_start_cmd),
    .active(head_delay)
  );

  // ************************************************************
  // Address registers
  // ************************************************************
  reg [`DTC_SECTOR_W-1:0] sector_addr;

  // Field, track and sector latches
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mem_field <= {`DTC_FIELD_W{1'b0}};
      track_addr <= {`DTC_TRACK_W{1'b0}};
      sector_addr <= {`DTC_SECTOR_W{1'b0}};
    end else begin
      if (ext_addr_load_cmd) begin
        mem_field <= buffered_accumulator[`DTC_FIELD_HI:`DTC_FIELD_LO];
      end
      if (track_load_and_start_cmd) begin
        track_addr <= buffered_accumulator[`DTC_TRACK_HI:0];
      end
      if (sector_load_cmd) begin
        sector_addr <= buffered_accumulator[`DTC_SECTOR_HI:0];
      end
    end
  end

  // ************************************************************
  // Sector counter and comparator
  // ************************************************************
  reg [`DTC_SECTOR_W-1:0] sector_count;
  wire sector_equal;

  // Index clears, sector pulse advances
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sector_count <= {`DTC_SECTOR_W{1'b0}};
    end else if (index_edge) begin
      sector_count <= {`DTC_SECTOR_W{1'b0}};
    end else if (sector_edge) begin
      sector_count <= sector_count + 8'h01;
    end
  end

  // Comparison is blanked while the heads settle
  assign sector_equal = (sector_count == sector_addr) & ~head_delay;

  // ************************************************************
  // Start flops and busy
  // ************************************************************
  reg read_start;
  reg write_start;
  reg wc_ovf_latched;
  reg match;
  wire stop_now;
  wire fault_stop;

  assign busy = read_start | write_start;
  assign fault_stop = illegal | sector_missing;

  // Shutdown strobed at sector pulse time
  assign stop_now = sector_edge & wc_ovf_latched & forty_words
                    & (~write_start | empty_lvl);

  // Start selection from accumulator bit 00
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      read_start <= 1'b0;
      write_start <= 1'b0;
    end else if (clear_flag_cmd) begin
      read_start <= 1'b0;
      write_start <= 1'b0;
    end else if (track_load_and_start_cmd) begin
      read_start <= ~buffered_accumulator[`DTC_AC_B00];
      write_start <= buffered_accumulator[`DTC_AC_B00];
    end else if (stop_now | fault_stop) begin
      read_start <= 1'b0;
      write_start <= 1'b0;
    end
  end

  // Overflow latch from the word-count board
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wc_ovf_latched <= 1'b0;
    end else if (wc_ovf_lvl & busy) begin
      wc_ovf_latched <= 1'b1;
    end else if (~busy) begin
      wc_ovf_latched <= 1'b0;
    end
  end

  // ************************************************************
  // Match flop and data board activation
  // ************************************************************
  // Sets at sector pulse after equality, holds until idle
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      match <= 1'b0;
    end else if (~busy) begin
      match <= 1'b0;
    end else if (sector_edge & sector_equal & drum_break_request) begin
      match <= 1'b1;
    end
  end

  // Activation is gated by sector pulse, illegal and sector-missing
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_board_activate <= 1'b0;
    end else begin
      data_board_activate <= match & ~sector_lvl & ~fault_stop;
    end
  end

  // Mode outputs follow the start flops
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      read_match <= 1'b0;
      write_match <= 1'b0;
    end else begin
      read_match <= read_start;
      write_match <= write_start;
    end
  end

  assign write_enable = write_match;
  assign derand_activate = read_match;

  // ************************************************************
  // Forty-word counter
  // ************************************************************
  reg [`DTC_WORD_W-1:0] word_count;
  reg match_d;

  // Remember match to catch its rising edge
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      match_d <= 1'b0;
    end else begin
      match_d <= match;
    end
  end

  // Counts last-bit pulses, cleared by sector pulse or new match
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      word_count <= {`DTC_WORD_W{1'b0}};
      forty_words <= 1'b0;
    end else if ((match & ~match_d) | sector_edge) begin
      word_count <= {`DTC_WORD_W{1'b0}};
      forty_words <= 1'b0;
    end else if (last_word_last_bit_pulse_edge & data_board_activate & ~forty_words) begin
      word_count <= word_count + 6'h01;
      forty_words <= (word_count + 6'h01) == `DTC_WORDS_PER_SECTOR;
    end
  end

  // ************************************************************
  // Break request
  // ************************************************************
  // Follows the buffer while running and no overflow
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      drum_break_request <= 1'b0;
    end else begin
      drum_break_request <= break_lvl & busy & ~wc_ovf_latched & ~wc_ovf_lvl;
    end
  end

  // ************************************************************
  // Sector-not-found and illegal status
  // ************************************************************
  reg [1:0] index_stage;
  reg busy_d;

  // Two-stage index count while searching
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      index_stage <= 2'h0;
    end else if (~busy | match) begin
      index_stage <= 2'h0;
    end else if (index_edge) begin
      index_stage <= {index_stage[0], 1'b1};
    end
  end

  // Sticky sector-missing; set beats clear
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sector_missing <= 1'b0;
    end else if (busy & index_stage[1]) begin
      sector_missing <= 1'b1;
    end else if (track_load_and_start_cmd & (sector_addr > `DTC_SECTOR_MAX)) begin
      sector_missing <= 1'b1;
    end else if (clear_flag_cmd) begin
      sector_missing <= 1'b0;
    end
  end

  // Illegal only with busy and a drum or sync fault
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      illegal <= 1'b0;
    end else if (busy & (~ready_s | sector_missing)) begin
      illegal <= 1'b1;
    end else if (clear_flag_cmd) begin
      illegal <= 1'b0;
    end
  end

  // Data error from the data board
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_error <= 1'b0;
    end else if (data_err_edge) begin
      data_error <= 1'b1;
    end else if (clear_flag_cmd) begin
      data_error <= 1'b0;
    end
  end

  // ************************************************************
  // Done flag and interrupt
  // ************************************************************
  // Remember busy to see it fall
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      busy_d <= 1'b0;
    end else begin
      busy_d <= busy;
    end
  end

  // Done sets on busy falling; set beats clear
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      done_flag <= 1'b0;
    end else if (busy_d & ~busy) begin
      done_flag <= 1'b1;
    end else if (clear_flag_cmd) begin
      done_flag <= 1'b0;
    end
  end

  assign interrupt_request = done_flag | illegal | sector_missing;

  // ************************************************************
  // Accumulator answers
  // ************************************************************
  // Status word and accumulator clear, one cycle after the command
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ac_in <= `DTC_AC_ZERO;
      ac_clear <= 1'b0;
    end else begin
      ac_clear <= ext_addr_load_cmd | sector_load_cmd
                  | track_load_and_start_cmd | status_read_cmd;
      ac_in <= `DTC_AC_ZERO;
      if (status_read_cmd) begin
        ac_in[`DTC_AC_B00] <= ~ready_s;
        ac_in[`DTC_AC_B01] <= sector_missing;
        ac_in[`DTC_AC_B02] <= busy;
        ac_in[`DTC_AC_B03] <= data_error;
      end
    end
  end

endmodule // dtc_top
`default_nettype wire

// file: tb/dtc_assertions.sv
// Port checker for the drum transfer control block
`timescale 1ns/10ps
`default_nettype none
`include "dtc_consts.vh"
module dtc_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Processor side
  input wire logic ext_addr_load_cmd,
  input wire logic track_load_and_start_cmd,
  input wire logic status_read_cmd,
  input wire logic clear_flag_cmd,
  input wire logic [`DTC_AC_W-1:0] buffered_accumulator,
  input wire logic [`DTC_AC_W-1:0] ac_in,
  input wire logic ac_clear,
  input wire logic [`DTC_FIELD_W-1:0] mem_field,
  input wire logic done_flag,
  input wire logic interrupt_request,
  // Drum and data board side
  input wire logic [`DTC_TRACK_W-1:0] track_addr,
  input wire logic read_match,
  input wire logic write_match,
  input wire logic write_enable,
  input wire logic derand_activate,
  input wire logic data_board_activate,
  input wire logic drum_break_request,
  // Status
  input wire logic busy,
  input wire logic sector_missing,
  input wire logic illegal
);
  // ****
  // Helper logic and properties
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [10:0] since_trk;
  // Cycles since the last track load, saturating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) since_trk <= 11'h7FF;
    else if (track_load_and_start_cmd) since_trk <= 11'h000;
    else if (since_trk != 11'h7FF) since_trk <= since_trk + 11'h001;
  end
  property p_field;
    ext_addr_load_cmd |=> ac_clear && mem_field == $past(buffered_accumulator[5:3]);
  endproperty
  a_field: assert property (p_field) else $error("field load wrong");
  property p_nocarry;
    !ext_addr_load_cmd |=> $stable(mem_field);
  endproperty
  a_nocarry: assert property (p_nocarry) else $error("field changed");
  property p_track;
    track_load_and_start_cmd |=> busy && track_addr == $past(buffered_accumulator[8:0]);
  endproperty
  a_track: assert property (p_track) else $error("track load wrong");
  property p_match;
    write_enable == write_match && derand_activate == read_match && !(read_match && write_match);
  endproperty
  a_match: assert property (p_match) else $error("match outputs wrong");
  property p_stat;
    status_read_cmd |=> ac_clear && ac_in[9] == $past(busy) && ac_in[10] == $past(sector_missing);
  endproperty
  a_stat: assert property (p_stat) else $error("status word wrong");
  property p_quiet;
    !status_read_cmd |=> ac_in == `DTC_AC_ZERO;
  endproperty
  a_quiet: assert property (p_quiet) else $error("status not idle");
  property p_done;
    $fell(busy) && !$past(clear_flag_cmd) |=> done_flag;
  endproperty
  a_done: assert property (p_done) else $error("done not set");
  property p_irq;
    interrupt_request == (done_flag || illegal || sector_missing);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt wrong");
  property p_idle;
    (!busy) [*2] |-> !drum_break_request;
  endproperty
  a_idle: assert property (p_idle) else $error("break while idle");
  property p_hold;
    $rose(data_board_activate) |-> busy && since_trk >= `DTC_HEAD_DELAY_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("start inside head delay");
  property p_ill;
    $rose(illegal) |-> busy || $past(busy);
  endproperty
  a_ill: assert property (p_ill) else $error("illegal while idle");
  c_read: cover property (read_match && data_board_activate);
  c_write: cover property (write_match && data_board_activate);
  c_miss: cover property ($rose(sector_missing));
  c_ill: cover property ($rose(illegal));
endmodule // dtc_assertions
bind dtc_top dtc_assertions u_chk (.*);
`default_nettype wire

// file: tb/dtc_drum_model.sv
// Drum timing tracks and data board word pulses
`timescale 1ns/10ps
`default_nettype none
module dtc_drum_model #(
  parameter int NSEC = 8,
  parameter int SLEN = 96
) (
  // Controller state
  input wire logic data_board_activate,
  // Timing tracks and word pulses
  output logic sector_pulse = 1'b0,
  output logic index_pulse = 1'b0,
  output logic last_word_last_bit_pulse = 1'b0
);
  // ****
  // Free running drum position
  // ****
  logic lclk = 1'b0;
  int pos = 0;
  int sec = 0;
  // Link clock, offset so its edges never meet the core clock
  initial begin
    #137;
    forever #400 lclk = ~lclk;
  end
  // Position steps once per link clock
  always @(posedge lclk) begin
    pos <= (pos == SLEN - 1) ? 0 : pos + 1;
    if (pos == SLEN - 1) sec <= (sec == NSEC - 1) ? 0 : sec + 1;
  end
  // Each pulse lasts one link period; forty word pulses per active sector
  always @(posedge lclk) begin
    sector_pulse <= (pos == SLEN - 1);
    index_pulse <= (sec == NSEC - 1) && (pos == SLEN - 8);
    last_word_last_bit_pulse <= data_board_activate && pos[0] && pos >= 3 && pos <= 81;
  end
endmodule // dtc_drum_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the drum transfer control block
`timescale 1ns/10ps
`default_nettype none
`include "dtc_consts.vh"
module tb_top;
  // ****
  // Stimulus, outputs and helpers
  // ****
  localparam int EXT = 0, SEC = 1, TRK = 2, STA = 3, CLR = 4;
  localparam int BSY = 0, DBA = 1, FW = 2, SM = 3, ILL = 4, DE = 5, DN = 6;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] cv = 5'h00;
  logic [`DTC_AC_W-1:0] buffered_accumulator = 12'h000;
  logic drum_ready = 1'b1;
  logic buffer_break_req = 1'b1;
  logic buffer_empty = 1'b0;
  logic word_count_overflow = 1'b0;
  logic data_error_in = 1'b0;
  logic [11:0] got = 12'h000;
  logic aclr = 1'b0;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  wire [`DTC_AC_W-1:0] ac_in;
  wire [`DTC_FIELD_W-1:0] mem_field;
  wire [`DTC_TRACK_W-1:0] track_addr;
  wire ac_clear, done_flag, interrupt_request, sector_pulse, index_pulse;
  wire last_word_last_bit_pulse, read_match, write_match, write_enable, derand_activate;
  wire data_board_activate, forty_words, drum_break_request, busy, sector_missing;
  wire illegal, data_error;
  // Design and drum
  dtc_top u_dut (
    .ext_addr_load_cmd(cv[0]),
    .sector_load_cmd(cv[1]),
    .track_load_and_start_cmd(cv[2]),
    .status_read_cmd(cv[3]),
    .clear_flag_cmd(cv[4]),
    .*
  );
  dtc_drum_model u_drum (
    .data_board_activate(data_board_activate),
    .sector_pulse(sector_pulse),
    .index_pulse(index_pulse),
    .last_word_last_bit_pulse(last_word_last_bit_pulse)
  );
  always #50 core_clk = ~core_clk;
  // Cycle ceiling against hangs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One command pulse; the one-cycle answer is caught while it stands
  task automatic cmd(input int k, input logic [11:0] v);
    @(negedge core_clk);
    buffered_accumulator = v;
    cv = 5'h01 << k;
    @(negedge core_clk);
    got = ac_in;
    aclr = ac_clear;
    cv = 5'h00;
  endtask
  function automatic logic sel(input int w);
    case (w)
      BSY: return busy;
      DBA: return data_board_activate;
      FW: return forty_words;
      SM: return sector_missing;
      ILL: return illegal;
      DE: return data_error;
      default: return done_flag;
    endcase
  endfunction
  // Bounded wait for a level, then compare it
  task automatic waitv(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (sel(w) !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk(12'(sel(w)), 12'(v));
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(12'({busy, done_flag, interrupt_request}), 12'h000);
    cmd(EXT, 12'h028);
    chk(12'({aclr, mem_field}), 12'h00D);
    // Two-sector read, stopped by overflow
    cmd(SEC, 12'h002);
    cmd(TRK, 12'h1A5);
    @(negedge core_clk);
    chk(12'({busy, read_match, derand_activate, write_enable}), 12'h00E);
    chk(12'(track_addr), 12'h1A5);
    cmd(STA, 12'h000);
    chk(got & 12'hF00, 12'h200);
    waitv(DBA, 1'b1, 7000);
    waitv(FW, 1'b1, 800);
    waitv(FW, 1'b0, 800);
    chk(12'(busy), 12'h001);
    waitv(FW, 1'b1, 800);
    word_count_overflow = 1'b1;
    waitv(BSY, 1'b0, 900);
    waitv(DN, 1'b1, 2);
    chk(12'({interrupt_request, drum_break_request}), 12'h002);
    cmd(CLR, 12'h000);
    chk(12'(done_flag), 12'h000);
    // Write waits for an empty buffer before stopping
    word_count_overflow = 1'b0;
    cmd(SEC, 12'h005);
    cmd(TRK, 12'h8C3);
    @(negedge core_clk);
    chk(12'({busy, write_enable, read_match}), 12'h006);
    chk(12'(track_addr), 12'h0C3);
    waitv(DBA, 1'b1, 7000);
    word_count_overflow = 1'b1;
    waitv(FW, 1'b1, 800);
    waitv(FW, 1'b0, 800);
    chk(12'(busy), 12'h001);
    buffer_empty = 1'b1;
    waitv(BSY, 1'b0, 900);
    waitv(DN, 1'b1, 2);
    buffer_empty = 1'b0;
    word_count_overflow = 1'b0;
    cmd(CLR, 12'h000);
    // Sector address out of range
    cmd(SEC, 12'h050);
    cmd(TRK, 12'h000);
    waitv(SM, 1'b1, 20);
    waitv(DN, 1'b1, 20);
    cmd(STA, 12'h000);
    chk(got & 12'h400, 12'h400);
    cmd(CLR, 12'h000);
    chk(12'({sector_missing, done_flag}), 12'h000);
    // Sector that the drum never reaches
    cmd(SEC, 12'h03F);
    cmd(TRK, 12'h000);
    waitv(SM, 1'b1, 14000);
    waitv(BSY, 1'b0, 4);
    cmd(CLR, 12'h000);
    // Drum drops ready while busy
    cmd(SEC, 12'h002);
    cmd(TRK, 12'h000);
    drum_ready = 1'b0;
    waitv(ILL, 1'b1, 20);
    cmd(STA, 12'h000);
    chk(got & 12'h800, 12'h800);
    chk(12'({interrupt_request, busy}), 12'h002);
    drum_ready = 1'b1;
    cmd(CLR, 12'h000);
    chk(12'(illegal), 12'h000);
    // Data error status and its clear
    data_error_in = 1'b1;
    waitv(DE, 1'b1, 10);
    data_error_in = 1'b0;
    cmd(STA, 12'h000);
    chk(got & 12'h100, 12'h100);
    cmd(CLR, 12'h000);
    chk(12'(data_error), 12'h000);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
